// File: bench/irq_ctrl_monitor.sv
// Purpose: port checker of the interrupt controller
// Assumes: one clock, synchronous reset
// Notes: bound to every controller
`timescale 1ns/10ps
`include "irq_ctrl_defs.vh"
module irq_ctrl_monitor (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // pins and outputs
   input wire [7:0] irq_pin_n,
   input wire core_irq,
   input wire core_nmi,
   input wire lowpower_exit
);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire rd = wb_ack_o && !wb_we_i;
   wire mapped = wb_adr_i == `OFS_PENDING || wb_adr_i == `OFS_MASK || wb_adr_i == `OFS_SENSE;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("ack late");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   AST_ACK_REQ: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack");
   AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> !core_irq && !core_nmi
      && !lowpower_exit) else $error("output after reset");
   AST_WAKE_CAUSE: assert property (lowpower_exit |-> $past(irq_pin_n, 3) != 8'hFF)
      else $error("wake without low pin");
   AST_VEC_FORMAT: assert property (rd && wb_adr_i == `OFS_VECTOR |->
      wb_dat_o[25:0] == 26'h0 && wb_dat_o[31:24] <= `CODE_NONE) else $error("vector form");
   AST_REG_UPPER: assert property (rd && mapped |-> wb_dat_o[31:16] == `UPPER_ZERO)
      else $error("upper bits");
   AST_UNMAPPED: assert property (rd && !mapped && wb_adr_i != `OFS_VECTOR |->
      wb_dat_o == `WORD_ZERO) else $error("unmapped read");
   AST_DAT_HOLD: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
      else $error("read data moved");
endmodule // irq_ctrl_monitor
bind system_interrupt_priority_ctrl irq_ctrl_monitor mon (.sys_clk(sys_clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pin_n(irq_pin_n), .core_irq(core_irq),
   .core_nmi(core_nmi), .lowpower_exit(lowpower_exit));

// File: bench/irq_far_side.sv
// Purpose: far side model, request pins and level requestors
// Assumes: bench gives the wanted pattern
// Notes: released pins rest high on pull-ups
`timescale 1ns/10ps
module irq_far_side (
   // clock
   input wire sys_clk,
   // wanted pattern
   input wire [7:0] pin_low_req,
   input wire [7:0] level_req,
   // toward controller
   output reg [7:0] irq_pin_n = 8'hFF,
   output reg [7:0] internal_level_req = 8'h00
);
   always @(posedge sys_clk) begin
      irq_pin_n <= ~pin_low_req;
      internal_level_req <= level_req;
   end
endmodule // irq_far_side

// File: bench/system_interrupt_priority_ctrl_test.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: seeded random stimulus
// Notes: expectations come from bench functions
`timescale 1ns/10ps
`include "irq_ctrl_defs.vh"
module system_interrupt_priority_ctrl_test;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg wb_we_i = 1'b0;
   reg [3:0] wb_adr_i = 4'h0;
   reg [31:0] wb_dat_i = 32'h0;
   reg [3:0] wsel = 4'hF;
   reg [7:0] pin_lo = 8'h00;
   reg [7:0] lv = 8'h00;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, core_irq, core_nmi, lowpower_exit;
   wire [7:0] pins_n, lvl;
   integer n_fail = 0;
   integer num_checks = 0;
   integer i;
   reg [31:0] rdata;
   reg [15:0] m, p;
   irq_far_side far (.sys_clk(sys_clk), .pin_low_req(pin_lo), .level_req(lv),
      .irq_pin_n(pins_n), .internal_level_req(lvl));
   system_interrupt_priority_ctrl dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wsel),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pin_n(pins_n),
      .internal_level_req(lvl), .core_irq(core_irq), .core_nmi(core_nmi),
      .lowpower_exit(lowpower_exit));
   function [15:0] pend(input [7:0] pl, input [7:0] l);
      integer k;
      for (k = 0; k < 8; k = k + 1) begin
         pend[2*k] = pl[k];
         pend[2*k+1] = l[k];
      end
   endfunction
   function [31:0] vec(input [15:0] pm);
      integer k;
      vec = 32'h40000000;
      for (k = 15; k >= 0; k = k - 1)
         if (pm[k]) vec = {k[5:0], 26'h0};
   endfunction
   task cmp(input [63:0] nm, input [31:0] e, input [31:0] s);
      num_checks = num_checks + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task wb(input [3:0] a, input w, input [31:0] d);
      integer t;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      t = 0;
      do begin
         @(posedge sys_clk);
         t = t + 1;
      end while (wb_ack_o !== 1'b1 && t < 20);
      if (t >= 20) n_fail = n_fail + 1;
      rdata = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task rdchk(input [3:0] a, input [31:0] e, input [63:0] nm);
      wb(a, 1'b0, 32'h0);
      cmp(nm, e, rdata);
   endtask
   task finish_test;
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial forever #4 sys_clk = ~sys_clk;
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail = n_fail + 1;
      finish_test;
   end
   initial begin
      i = $urandom(32'hdcfc56f3);
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(`OFS_PENDING, 32'h0, "pend");
      rdchk(`OFS_MASK, 32'h0, "mask");
      rdchk(`OFS_SENSE, 32'h0, "sense");
      rdchk(`OFS_VECTOR, 32'h40000000, "vector");
      rdchk(4'h6, 32'h0, "unmapped");
      for (i = 0; i < 16; i = i + 1) begin
         m = (i == 0) ? 16'hFFFF : $urandom;
         wb(`OFS_MASK, 1'b1, {16'h0000, m});
         @(posedge sys_clk);
         pin_lo <= $urandom;
         lv <= (i == 1) ? 8'h00 : $urandom;
         repeat (6) @(posedge sys_clk);
         p = pend(pin_lo, lv);
         rdchk(`OFS_MASK, {16'h0, m}, "mask");
         wb(`OFS_PENDING, 1'b1, 32'hFFFF);
         rdchk(`OFS_PENDING, {16'h0, p}, "pend");
         rdchk(`OFS_VECTOR, vec(p & m), "vector");
         cmp("irq", {31'h0, |(p & m & 16'hFFFE)}, {31'h0, core_irq});
         cmp("nmi", {31'h0, p[0] & m[0]}, {31'h0, core_nmi});
      end
      wsel <= 4'h2;
      wb(`OFS_MASK, 1'b1, 32'h0000FFFF);
      wsel <= 4'hF;
      rdchk(`OFS_MASK, {16'h0, 8'hFF, m[7:0]}, "lanes");
      @(posedge sys_clk);
      {pin_lo, lv} <= 16'h0;
      repeat (6) @(posedge sys_clk);
      wb(`OFS_SENSE, 1'b1, 32'h00005555);
      rdchk(`OFS_SENSE, 32'h5555, "sense");
      pin_lo <= 8'hFF;
      repeat (6) @(posedge sys_clk);
      pin_lo <= 8'h00;
      repeat (6) @(posedge sys_clk);
      rdchk(`OFS_PENDING, 32'h5555, "edge");
      wb(`OFS_PENDING, 1'b1, 32'h0005);
      rdchk(`OFS_PENDING, 32'h5550, "clear");
      wb(`OFS_SENSE, 1'b1, 32'hAAAA);
      cmp("wake", 32'h0, {31'h0, lowpower_exit});
      pin_lo <= 8'h80;
      repeat (5) @(posedge sys_clk);
      cmp("wake", 32'h1, {31'h0, lowpower_exit});
      finish_test;
   end
endmodule // system_interrupt_priority_ctrl_test

// File: rtl/irq_ctrl_defs.vh
// Purpose: constants of the system interrupt priority controller
// Assumes: included by bare name from the rtl files
// Notes: definitions only
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// register byte offsets on the wishbone slave
`define OFS_PENDING 4'h0
`define OFS_MASK 4'h4
`define OFS_SENSE 4'h8
`define OFS_VECTOR 4'hC

// reset values
`define PENDING_RST 16'h0000
`define MASK_RST 16'h0000
`define SENSE_RST 16'h0000

// field layout
`define NUM_PINS 8
`define NUM_LANES 4
`define LANE_W 8
`define NUM_SRC 16
`define REG_W 16
`define PIN_NMI 0
`define SRC_IDX_W 4
`define CODE_W 8
`define CODE_LSB_PAD 2'h0
`define CODE_MSB_PAD 2'h0
`define CODE_NONE 8'h40
`define VEC_LOW_ZERO 24'h000000
`define UPPER_ZERO 16'h0000
`define WORD_ZERO 32'h00000000

`endif

// File: rtl/irq_pin_sync.v
// Purpose: synchronise the active-low request pins and find falling edges
// Assumes: pins are asynchronous to sys_clk
// Notes: stage one is read only by stage two
`timescale 1ns/10ps
`include "irq_ctrl_defs.vh"

module irq_pin_sync (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // raw pins
   input wire [`NUM_PINS-1:0] irq_pin_n,
   // synchronised results
   output wire [`NUM_PINS-1:0] pin_low,
   output wire [`NUM_PINS-1:0] pin_fall
);

   reg [`NUM_PINS-1:0] meta;
   reg [`NUM_PINS-1:0] sync;
   reg [`NUM_PINS-1:0] prev;

   genvar i;
   generate
      for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_pin
         always @(posedge sys_clk) begin
            if (rst) begin
               meta[i] <= 1'b1;
               sync[i] <= 1'b1;
               prev[i] <= 1'b1;
            end else begin
               meta[i] <= irq_pin_n[i];
               sync[i] <= meta[i];
               prev[i] <= sync[i];
            end
         end
         assign pin_low[i] = ~sync[i];
         // previous sample high, current low
         assign pin_fall[i] = prev[i] & ~sync[i];
      end
   endgenerate

endmodule // irq_pin_sync

// File: rtl/system_interrupt_priority_ctrl.v
// Purpose: system interrupt controller with pending, mask, sense and vector registers
// Assumes: classic wishbone slave on sys_clk, synchronous active-high reset
// Notes: pin 0 drives core_nmi behind its mask bit; the other sources share core_irq
`timescale 1ns/10ps
`include "irq_ctrl_defs.vh"

// Contract
// - All ordinary sources merge into one core request, high while any enabled one is pending.
// - External pin 0 drives the nmi request behind its mask bit; pins 1-7 and the eight levels feed the ordinary one.
// - Priority is fixed and interleaved, pin n above level n above pin n+1, pin 0 highest.
// - Each source code is four times its priority position, positions 16 to 31 reserved.
// - The pending register has one bit per source, pins on even and levels on odd bits, reset zero.
// - Internal level pending bits follow the live level request and ignore software writes.
// - A level-sensed pin's pending bit tracks the low pin level and ignores software writes.
// - An edge-sensed pin's pending bit sets on a falling edge and clears when software writes one.
// - Each mask bit sits beside its pending bit and lets that source reach its core request, core_nmi for pin 0 and core_irq for the rest.
// - The mask register is read/write and resets to zero so every source starts disabled.
// - The sense register holds edge select at bit 2n and wake enable at bit 2n+1 per pin, reset zero.
// - Edge select one senses a falling edge, zero senses a low level.
// - A set wake enable raises the low-power exit signal while its pin is low.
// - The read-only vector register gives the winning pending unmasked code in its top byte.
module system_interrupt_priority_ctrl (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   // external request pins, active low
   input wire [`NUM_PINS-1:0] irq_pin_n,
   // internal level requests
   input wire [`NUM_PINS-1:0] internal_level_req,
   // toward the core and power control
   output reg core_irq,
   output reg core_nmi,
   output reg lowpower_exit
);

   // registers
   reg [`REG_W-1:0] irq_pending;
   reg [`REG_W-1:0] irq_enable_mask;
   reg [`REG_W-1:0] irq_sense_wake_config;
   reg ack;

   // next values
   reg [`REG_W-1:0] next_pending;
   reg [`REG_W-1:0] next_mask;
   reg [`REG_W-1:0] next_sense;
   reg [31:0] next_dat;

   // synchronised pins
   wire [`NUM_PINS-1:0] pin_low;
   wire [`NUM_PINS-1:0] pin_fall;

   // field views
   wire [`NUM_PINS-1:0] edge_select;
   wire [`NUM_PINS-1:0] wake_enable;
   wire [`NUM_PINS-1:0] external_pin_enable;
   wire [`NUM_PINS-1:0] internal_level_enable;
   wire [`NUM_PINS-1:0] internal_level_pending;
   wire [`NUM_PINS-1:0] external_pin_pending;
   wire [`NUM_PINS-1:0] wake_hit;
   wire [`NUM_PINS-1:0] level_hit;
   wire ordinary_req;
   wire nmi_req;
   wire wake_req;

   // bus decode
   wire bus_req;
   wire take_req;
   wire wr_en;
   wire sel_pending;
   wire sel_mask;
   wire sel_sense;
   wire [31:0] lane_mask;
   wire [`REG_W-1:0] wr_lanes;
   wire [`REG_W-1:0] wr_data;
   wire [`REG_W-1:0] clear_req;

   // priority
   wire [`REG_W-1:0] active;
   reg [`SRC_IDX_W-1:0] win_idx;
   reg win_any;
   integer k;
   wire [`NUM_SRC:0] taken;
   wire [`NUM_SRC-1:0] first_hit;
   wire [`CODE_W-1:0] irq_vector_code;

   irq_pin_sync u_pin_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .irq_pin_n(irq_pin_n),
      .pin_low(pin_low),
      .pin_fall(pin_fall)
   );

   // split the interleaved registers into per-pin fields
   genvar i;
   generate
      for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_field
         assign edge_select[i] = irq_sense_wake_config[2*i];
         assign wake_enable[i] = irq_sense_wake_config[2*i+1];
         assign external_pin_enable[i] = irq_enable_mask[2*i];
         assign internal_level_enable[i] = irq_enable_mask[2*i+1];
         assign internal_level_pending[i] = irq_pending[2*i+1];
         assign external_pin_pending[i] = irq_pending[2*i];
      end
   endgenerate

   // wishbone decode
   assign bus_req = wb_cyc_i & wb_stb_i;
   // a request is taken on the edge where it stands and no answer is out
   assign take_req = bus_req & ~ack;
   assign wr_en = bus_req & wb_we_i & ack;
   assign sel_pending = (wb_adr_i == `OFS_PENDING);
   assign sel_mask = (wb_adr_i == `OFS_MASK);
   assign sel_sense = (wb_adr_i == `OFS_SENSE);
   // every byte lane select widens to a byte of the write mask
   generate
      for (i = 0; i < `NUM_LANES; i = i + 1) begin : g_lane
         assign lane_mask[`LANE_W*i+`LANE_W-1:`LANE_W*i] = {`LANE_W{wb_sel_i[i]}};
      end
   endgenerate
   // reserved upper half is never stored, whatever software writes
   assign wr_lanes = lane_mask[`REG_W-1:0];
   assign wr_data = wb_dat_i[`REG_W-1:0];
   assign clear_req = (wr_en & sel_pending) ? (wr_data & wr_lanes) : `PENDING_RST;

   // one-cycle answer, dropped in the cycle after it was given
   always @(posedge sys_clk) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= take_req;
      end
   end
   assign wb_ack_o = ack;

   // pending bits
   generate
      for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_pend
         wire edge_keep;
         wire edge_next;
         wire level_next;
         // edge mode keeps the bit until software writes a one to it
         assign edge_keep = irq_pending[2*i] & ~clear_req[2*i];
         // a new edge wins over a clear in the same cycle
         assign edge_next = edge_keep | pin_fall[i];
         // level mode follows the low pin and ignores writes
         assign level_next = pin_low[i];
         always @* begin
            if (edge_select[i]) begin
               next_pending[2*i] = edge_next;
            end else begin
               next_pending[2*i] = level_next;
            end
            // level bits follow the requestor and ignore writes
            next_pending[2*i+1] = internal_level_req[i];
         end
      end
   endgenerate

   // configuration writes honour the byte lanes
   always @* begin
      next_mask = irq_enable_mask;
      if (wr_en & sel_mask) begin
         next_mask = (irq_enable_mask & ~wr_lanes) | (wr_data & wr_lanes);
      end
   end

   always @* begin
      next_sense = irq_sense_wake_config;
      if (wr_en & sel_sense) begin
         next_sense = (irq_sense_wake_config & ~wr_lanes) | (wr_data & wr_lanes);
      end
   end

   // pending bits clear on reset and otherwise take their next value
   always @(posedge sys_clk) begin
      if (rst) begin
         irq_pending <= `PENDING_RST;
      end else begin
         irq_pending <= next_pending;
      end
   end

   // every source starts disabled
   always @(posedge sys_clk) begin
      if (rst) begin
         irq_enable_mask <= `MASK_RST;
      end else begin
         irq_enable_mask <= next_mask;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         irq_sense_wake_config <= `SENSE_RST;
      end else begin
         irq_sense_wake_config <= next_sense;
      end
   end

   // fixed priority: the lowest set bit wins
   assign active = irq_pending & irq_enable_mask;
   assign taken[0] = 1'b0;

   // a ladder from position 0 upward marks the first active source
   generate
      for (i = 0; i < `NUM_SRC; i = i + 1) begin : g_prio
         assign first_hit[i] = active[i] & ~taken[i];
         assign taken[i+1] = taken[i] | active[i];
      end
   endgenerate

   // one-hot winner to its position number
   always @* begin
      win_idx = {`SRC_IDX_W{1'b0}};
      for (k = 0; k < `NUM_SRC; k = k + 1) begin
         if (first_hit[k]) begin
            win_idx = win_idx | k[`SRC_IDX_W-1:0];
         end
      end
   end

   always @* begin
      win_any = taken[`NUM_SRC];
   end

   // code is the position shifted left by two
   assign irq_vector_code = win_any ? {`CODE_MSB_PAD, win_idx, `CODE_LSB_PAD} : `CODE_NONE;

   // read data, captured when the request is taken
   always @* begin
      next_dat = `WORD_ZERO;
      case (wb_adr_i)
         `OFS_PENDING: begin
            next_dat = {`UPPER_ZERO, irq_pending};
         end
         `OFS_MASK: begin
            next_dat = {`UPPER_ZERO, irq_enable_mask};
         end
         `OFS_SENSE: begin
            next_dat = {`UPPER_ZERO, irq_sense_wake_config};
         end
         `OFS_VECTOR: begin
            // code in the top byte, the rest reads zero
            next_dat = {irq_vector_code, `VEC_LOW_ZERO};
         end
         default: begin
            // unmapped offsets read as zero
            next_dat = `WORD_ZERO;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= `WORD_ZERO;
      end else if (take_req & ~wb_we_i) begin
         wb_dat_o <= next_dat;
      end
   end

   // ordinary request: pins 1 to 7 and all levels, each behind its mask bit
   generate
      for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_req
         assign level_hit[i] = internal_level_pending[i] & internal_level_enable[i];
         assign wake_hit[i] = wake_enable[i] & pin_low[i];
      end
   endgenerate
   assign ordinary_req = (|(external_pin_pending[`NUM_PINS-1:`PIN_NMI+1]
      & external_pin_enable[`NUM_PINS-1:`PIN_NMI+1])) | (|level_hit);
   // pin 0 is left out of the ordinary request
   assign nmi_req = external_pin_pending[`PIN_NMI] & external_pin_enable[`PIN_NMI];
   assign wake_req = |wake_hit;

   // outputs toward the core and the power controller
   always @(posedge sys_clk) begin
      if (rst) begin
         core_irq <= 1'b0;
      end else begin
         core_irq <= ordinary_req;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         core_nmi <= 1'b0;
      end else begin
         core_nmi <= nmi_req;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         lowpower_exit <= 1'b0;
      end else begin
         lowpower_exit <= wake_req;
      end
   end

endmodule // system_interrupt_priority_ctrl
